// File: hdl/eeprom_defs.svh
`ifndef EEPROM_DEFS_SVH
`define EEPROM_DEFS_SVH

// Array geometry
`define ADDR_W                   11
`define PAGE_W                   4
`define ROW_W                    7
`define HI_W                     3
`define PAGE_BYTES               16
`define FULL_ADDR_MASK           11'h7FF
`define SMALL_ADDR_MASK          11'h3FF

// Device address byte
`define DEV_CODE                 4'hA
`define LAST_BIT                 3'h7
`define FIRST_BIT                3'h1
`define ZERO_BIT                 3'h0

// Programming cycle timing
`define INTERNAL_PROGRAM_TIME_MS 5
`define NS_PER_MS                1000000
`define SYS_CLK_PERIOD_NS        25
`define PROG_CNT_W               18
`define COMMIT_LAST              18'h0000F

`endif

// File: hdl/eeprom_pkg.sv
package eeprom_pkg;

  typedef enum logic [3:0] {
    L_IDLE      = 4'h0,
    L_DEV       = 4'h1,
    L_DEV_ACK   = 4'h3,
    L_WADDR     = 4'h2,
    L_WADDR_ACK = 4'h6,
    L_WDATA     = 4'h7,
    L_WDATA_ACK = 4'h5,
    L_RDATA     = 4'hB,
    L_RACK      = 4'hF
  } link_state_t;

  typedef enum logic [1:0] {
    P_IDLE   = 2'h0,
    P_COMMIT = 2'h1,
    P_WAIT   = 2'h3
  } prog_state_t;

endpackage

// File: hdl/level_sync.sv
`timescale 1ns/1ps

module level_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Two stages; the first feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// File: hdl/twowire_eeprom_access.sv
`timescale 1ns/1ps
`include "eeprom_defs.svh"

module twowire_eeprom_access
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES =
    `INTERNAL_PROGRAM_TIME_MS * `NS_PER_MS / `SYS_CLK_PERIOD_NS,
  parameter bit LARGE_ARRAY = 1'b1
) (
  input  wire logic SYS_CLK,
  input  wire logic NRST,
  input  wire logic SCL,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE,
  input  wire logic WRITE_PROTECT,
  input  wire logic STRAP_SELECT_BIT,
  output logic      PROG_BUSY
);

  logic [7:0]             mem [0:(1<<`ADDR_W)-1];
  logic [7:0]             page_buf [0:`PAGE_BYTES-1];
  logic [`PAGE_BYTES-1:0] valid_reg;
  logic [`ROW_W-1:0]      row_reg;

  link_state_t            state_reg;
  logic [2:0]             bit_cnt_reg;
  logic [7:0]             shift_reg;
  logic [7:0]             tx_reg;
  logic [`ADDR_W-1:0]     addr_reg;
  logic [`HI_W-1:0]       hi_bits_reg;
  logic                   rw_reg;
  logic                   wr_armed_reg;
  logic                   start_tgl;
  logic                   start_seen_reg;
  logic                   stop_tgl;
  logic                   sda_oe_reg;
  logic                   done_sync;
  logic                   wp_sync;
  logic                   strap_sync;
  logic                   stop_sync;

  prog_state_t            pstate_reg;
  logic [`PROG_CNT_W-1:0] pcnt_reg;
  logic                   done_tgl;
  logic                   busy_reg;

  logic [7:0]             byte_in;
  logic                   start_now;
  logic                   busy_link;
  logic                   byte_done;
  logic                   read_load;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [`ADDR_W-1:0] wrap_addr(input logic [`ADDR_W-1:0] a);
    wrap_addr = a & (LARGE_ARRAY ? `FULL_ADDR_MASK : `SMALL_ADDR_MASK);
  endfunction

  function automatic logic dev_match(input logic [7:0] b, input logic strap);
    dev_match = (b[7:4] == `DEV_CODE) && (LARGE_ARRAY || (b[3] == strap));
  endfunction

  function automatic logic [`HI_W-1:0] page_sel(input logic [7:0] b);
    page_sel = LARGE_ARRAY ? b[3:1] : {1'b0, b[2:1]};
  endfunction
  assign byte_in   = {shift_reg[6:0], SDA_I};
  assign start_now = start_tgl ^ start_seen_reg;
  assign busy_link = stop_tgl ^ done_sync;
  assign byte_done = (bit_cnt_reg == `LAST_BIT);
  assign read_load = !start_now &&
                     (((state_reg == L_DEV_ACK) && rw_reg) ||
                      ((state_reg == L_RACK) && !SDA_I));

  ////////////////////////////////////////////////////////////////////////////
  // Pin and toggle synchronisers on the link clock and system clock

  level_sync #(.W(1)) u_wp_sync (
    .clk   (SCL),
    .rst_n (NRST),
    .d     (WRITE_PROTECT),
    .q     (wp_sync)
  );

  level_sync #(.W(1)) u_strap_sync (
    .clk   (SCL),
    .rst_n (NRST),
    .d     (STRAP_SELECT_BIT),
    .q     (strap_sync)
  );

  level_sync #(.W(1)) u_done_sync (
    .clk   (SCL),
    .rst_n (NRST),
    .d     (done_tgl),
    .q     (done_sync)
  );

  level_sync #(.W(1)) u_stop_sync (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .d     (stop_tgl),
    .q     (stop_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop detection on data edges while clock high

  always_ff @(negedge SDA_I or negedge NRST) begin
    if (!NRST) begin
      start_tgl <= 1'b0;
    end else if (SCL) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge SDA_I or negedge NRST) begin
    if (!NRST) begin
      stop_tgl <= 1'b0;
    end else if (SCL && wr_armed_reg && !busy_link) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state machine, sampled on rising clock

  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      state_reg      <= L_IDLE;
      bit_cnt_reg    <= `ZERO_BIT;
      shift_reg      <= 8'h00;
      start_seen_reg <= 1'b0;
      rw_reg         <= 1'b0;
      hi_bits_reg    <= '0;
    end else if (start_now) begin
      start_seen_reg <= start_tgl;
      state_reg      <= L_DEV;
      bit_cnt_reg    <= `FIRST_BIT;
      shift_reg      <= {7'h00, SDA_I};
    end else begin
      shift_reg   <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + `FIRST_BIT;
      case (state_reg)
        L_DEV: begin
          if (byte_done) begin
            rw_reg      <= byte_in[0];
            hi_bits_reg <= page_sel(byte_in);
            if (dev_match(byte_in, strap_sync) && !busy_link) begin
              state_reg <= L_DEV_ACK;
            end else begin
              state_reg <= L_IDLE;
            end
          end
        end
        L_DEV_ACK: begin
          bit_cnt_reg <= `ZERO_BIT;
          state_reg   <= rw_reg ? L_RDATA : L_WADDR;
        end
        L_WADDR: begin
          if (byte_done) begin
            state_reg <= L_WADDR_ACK;
          end
        end
        L_WADDR_ACK, L_WDATA_ACK: begin
          bit_cnt_reg <= `ZERO_BIT;
          state_reg   <= L_WDATA;
        end
        L_WDATA: begin
          if (byte_done) begin
            state_reg <= L_WDATA_ACK;
          end
        end
        L_RDATA: begin
          if (byte_done) begin
            state_reg <= L_RACK;
          end
        end
        L_RACK: begin
          bit_cnt_reg <= `ZERO_BIT;
          state_reg   <= SDA_I ? L_IDLE : L_RDATA;
        end
        default: begin
          state_reg <= L_IDLE;
        end
      endcase
    end
  end

  // Address counter
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      addr_reg <= '0;
      row_reg  <= '0;
    end else if (!start_now && byte_done && (state_reg == L_WADDR)) begin
      addr_reg <= wrap_addr({hi_bits_reg, byte_in});
      row_reg  <= {hi_bits_reg, byte_in[7:`PAGE_W]};
    end else if (!start_now && byte_done && (state_reg == L_WDATA)) begin
      addr_reg[`PAGE_W-1:0] <= addr_reg[`PAGE_W-1:0] + 4'h1;
    end else if (read_load) begin
      addr_reg <= wrap_addr(addr_reg + 11'h001);
    end
  end

  // Transmit byte load
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      tx_reg <= 8'hFF;
    end else if (read_load) begin
      tx_reg <= mem[addr_reg];
    end
  end

  // Page buffer capture, whole bytes only
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      valid_reg <= '0;
    end else if (!start_now && byte_done && (state_reg == L_WADDR)) begin
      valid_reg <= '0;
    end else if (!start_now && byte_done && (state_reg == L_WDATA)) begin
      valid_reg[addr_reg[`PAGE_W-1:0]] <= 1'b1;
    end
  end

  always_ff @(posedge SCL) begin
    if (!start_now && byte_done && (state_reg == L_WDATA)) begin
      page_buf[addr_reg[`PAGE_W-1:0]] <= byte_in;
    end
  end

  // Write arming; protect input blocks it
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      wr_armed_reg <= 1'b0;
    end else if (start_now) begin
      wr_armed_reg <= 1'b0;
    end else if (byte_done && (state_reg == L_WDATA) && !wp_sync) begin
      wr_armed_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data drive on falling clock, open drain

  always_ff @(negedge SCL or negedge NRST) begin
    if (!NRST) begin
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        L_DEV_ACK, L_WADDR_ACK, L_WDATA_ACK: begin
          sda_oe_reg <= 1'b1;
        end
        L_RDATA: begin
          sda_oe_reg <= !tx_reg[~bit_cnt_reg];
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign SDA_O  = 1'b0;
  assign SDA_OE = sda_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed programming on the system clock

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      pstate_reg <= P_IDLE;
      pcnt_reg   <= '0;
      done_tgl   <= 1'b0;
      busy_reg   <= 1'b0;
    end else begin
      case (pstate_reg)
        P_IDLE: begin
          pcnt_reg <= '0;
          if (stop_sync != done_tgl) begin
            pstate_reg <= P_COMMIT;
            busy_reg   <= 1'b1;
          end
        end
        P_COMMIT: begin
          pcnt_reg <= pcnt_reg + 18'h00001;
          if (pcnt_reg == `COMMIT_LAST) begin
            pstate_reg <= P_WAIT;
          end
        end
        P_WAIT: begin
          pcnt_reg <= pcnt_reg + 18'h00001;
          if (pcnt_reg == `PROG_CNT_W'(PROG_CYCLES - 1)) begin
            pstate_reg <= P_IDLE;
            done_tgl   <= ~done_tgl;
            busy_reg   <= 1'b0;
          end
        end
        default: begin
          pstate_reg <= P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if ((pstate_reg == P_COMMIT) && valid_reg[pcnt_reg[`PAGE_W-1:0]]) begin
      mem[{row_reg, pcnt_reg[`PAGE_W-1:0]}] <= page_buf[pcnt_reg[`PAGE_W-1:0]];
    end
  end

  assign PROG_BUSY = busy_reg;
endmodule

// File: dv/twowire_eeprom_access_sva.sv
`timescale 1ns/1ps
module twowire_eeprom_access_chk #(
  parameter int PROG_CYCLES = 40
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic WRITE_PROTECT,
  input wire logic STRAP_SELECT_BIT,
  input wire logic PROG_BUSY
);
  localparam int MIN_BUSY = PROG_CYCLES - 20;
  logic [31:0] busy_cnt_reg;
  // Length of the current busy period
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= PROG_BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////
  odrain_zero_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    SDA_O == 1'b0) else $error("data output value not low");
  drive_low_a: assert property (@(posedge SCL) disable iff (!NRST)
    SDA_OE |-> !SDA_I) else $error("driven data line not low");
  busy_quiet_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    PROG_BUSY |-> !SDA_OE) else $error("line driven while programming");
  busy_idle_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(PROG_BUSY) |-> SCL && SDA_I) else $error("programming began on busy bus");
  busy_hold_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(PROG_BUSY) |=> PROG_BUSY [*8]) else $error("programming ended at once");
  busy_min_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $fell(PROG_BUSY) |-> busy_cnt_reg >= MIN_BUSY) else $error("programming too short");
  busy_max_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    PROG_BUSY |-> busy_cnt_reg < PROG_CYCLES) else $error("programming too long");
  wp_no_prog_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    $rose(PROG_BUSY) |-> !WRITE_PROTECT) else $error("programming while protected");
  prog_c: cover property (@(posedge SYS_CLK) disable iff (!NRST) $rose(PROG_BUSY));
  done_c: cover property (@(posedge SYS_CLK) disable iff (!NRST) $fell(PROG_BUSY));
  ack_c: cover property (@(posedge SCL) disable iff (!NRST) SDA_OE);
endmodule

bind twowire_eeprom_access twowire_eeprom_access_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .WRITE_PROTECT(WRITE_PROTECT), .STRAP_SELECT_BIT(STRAP_SELECT_BIT),
  .PROG_BUSY(PROG_BUSY));

// File: dv/i2c_ctl_model.sv
`timescale 1ns/1ps
module i2c_ctl_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit slot of 48 ns, data set mid low
  task automatic bit_slot(input logic d, output logic q);
    scl = 1'b0;
    #12 sda_drv = d;
    #12 scl = 1'b1;
    #12 q = sda;
    #12;
  endtask
  // Start or repeated start
  task automatic start_c();
    scl = 1'b0;
    #12 sda_drv = 1'b1;
    #12 scl = 1'b1;
    #24 sda_drv = 1'b0;
    #24;
  endtask
  // Stop, then bus idle
  task automatic stop_c();
    scl = 1'b0;
    #12 sda_drv = 1'b0;
    #12 scl = 1'b1;
    #24 sda_drv = 1'b1;
    #150;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(b[i], q);
    end
    bit_slot(1'b1, ack);
  endtask
  // Release line for data, then own acknowledge
  task automatic get_byte(output logic [7:0] b, input logic nack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, b[i]);
    end
    bit_slot(nack, q);
  endtask
endmodule

// File: dv/twowire_eeprom_access_tb_top.sv
`timescale 1ns/1ps
module twowire_eeprom_access_tb_top;
  logic       sys_clk;
  logic       nrst;
  logic       wp;
  logic       scl;
  logic       sda_drv;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  logic       ack;
  logic [7:0] rd;
  int         failures;
  int         compares;
  wire        sda_w = sda_drv & (sda_oe ? sda_o : 1'b1);

  twowire_eeprom_access #(.PROG_CYCLES(40)) twowire_eeprom_access_i (
    .SYS_CLK(sys_clk), .NRST(nrst), .SCL(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .WRITE_PROTECT(wp), .STRAP_SELECT_BIT(1'b0), .PROG_BUSY(busy));
  i2c_ctl_model i2c_ctl_model_i (.scl(scl), .sda_drv(sda_drv), .sda(sda_w));
  ////////////////////////////////////////
  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Device address in write mode, then word address
  task automatic addr_frame(input logic [2:0] hi, input logic [7:0] wa);
    i2c_ctl_model_i.start_c();
    i2c_ctl_model_i.put_byte({4'hA, hi, 1'b0}, ack);
    check({7'h00, ack}, 8'h00);
    i2c_ctl_model_i.put_byte(wa, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  task automatic put_acked(input logic [7:0] b);
    i2c_ctl_model_i.put_byte(b, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  // Read-mode address after repeated start
  task automatic read_addr(input logic [2:0] hi);
    i2c_ctl_model_i.start_c();
    i2c_ctl_model_i.put_byte({4'hA, hi, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  // Acknowledge polling with bounded tries
  task automatic poll();
    int n;
    n = 0;
    ack = 1'b1;
    while (ack !== 1'b0) begin
      if (n == 20) begin
        failures++;
        end_of_test();
      end
      n++;
      i2c_ctl_model_i.start_c();
      i2c_ctl_model_i.put_byte(8'hA0, ack);
      i2c_ctl_model_i.stop_c();
    end
  endtask
  task automatic prog_byte(input logic [2:0] hi, input logic [7:0] wa, input logic [7:0] d);
    addr_frame(hi, wa);
    put_acked(d);
    i2c_ctl_model_i.stop_c();
    check({7'h00, busy}, 8'h01);
    i2c_ctl_model_i.start_c();
    i2c_ctl_model_i.put_byte(8'hA0, ack);
    check({7'h00, ack}, 8'h01);
    i2c_ctl_model_i.stop_c();
    poll();
  endtask
  ////////////////////////////////////////
  task automatic t_array_wrap();
    prog_byte(3'h7, 8'hFF, 8'hC3);
    prog_byte(3'h0, 8'h00, 8'h3C);
    addr_frame(3'h7, 8'hFF);
    read_addr(3'h7);
    i2c_ctl_model_i.get_byte(rd, 1'b0);
    check(rd, 8'hC3);
    i2c_ctl_model_i.get_byte(rd, 1'b1);
    check(rd, 8'h3C);
    i2c_ctl_model_i.stop_c();
  endtask
  // Eighteen bytes from offset E wrap in page; offset k ends as k+3
  task automatic t_page_wrap();
    addr_frame(3'h5, 8'h1E);
    for (int i = 0; i < 18; i++) begin
      put_acked(8'(i + 1));
    end
    i2c_ctl_model_i.stop_c();
    poll();
    addr_frame(3'h5, 8'h10);
    read_addr(3'h5);
    i2c_ctl_model_i.get_byte(rd, 1'b1);
    check(rd, 8'h03);
    i2c_ctl_model_i.stop_c();
    read_addr(3'h5);
    for (int k = 1; k < 16; k++) begin
      i2c_ctl_model_i.get_byte(rd, k == 15);
      check(rd, 8'(k + 3));
    end
    i2c_ctl_model_i.stop_c();
  endtask
  task automatic t_protect();
    @(negedge sys_clk) wp = 1'b1;
    #200;
    addr_frame(3'h5, 8'h10);
    put_acked(8'hEE);
    i2c_ctl_model_i.stop_c();
    check({7'h00, busy}, 8'h00);
    @(negedge sys_clk) wp = 1'b0;
    #200;
    addr_frame(3'h5, 8'h10);
    read_addr(3'h5);
    i2c_ctl_model_i.get_byte(rd, 1'b1);
    check(rd, 8'h03);
    i2c_ctl_model_i.stop_c();
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    failures = 0;
    compares = 0;
    nrst = 1'b0;
    wp = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_array_wrap();
    t_page_wrap();
    t_protect();
    end_of_test();
  end
endmodule
